// ### rssp_pkg.sv
// Purpose: Shared constants and types of the serial slave port.
// Assumes: 125 MHz ref clock, two-wire bus up to 400 kHz.
// Notes:   Contract
package rssp_pkg;
  localparam logic [6:0] SLAVE_ADDR    = 7'h68;  // Write form D0h
  localparam int         ADDR_W        = 6;
  localparam int         DATA_W        = 8;
  localparam int         MEM_DEPTH     = 64;
  localparam logic [5:0] ADDR_ZERO     = 6'h00;
  localparam logic [5:0] ADDR_ONE      = 6'h01;
  localparam logic [5:0] LAST_ADDR     = 6'h3F;
  localparam logic [5:0] CLOCK_LAST    = 6'h07;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_ZERO      = 4'h0;
  localparam logic [3:0] BIT_ONE       = 4'h1;
  // Timing
  localparam int CLK_PERIOD_NS         = 8;
  localparam int RECOVERY_HOLD_TIME_NS = 200000;
  localparam int REC_HOLD_CYCLES       =
    (RECOVERY_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         REC_CNT_W     = 20;
  localparam logic [19:0] REC_ZERO     = 20'h00000;
  localparam logic [19:0] REC_ONE      = 20'h00001;
  // Synchroniser lanes and their idle values
  localparam int         SYNC_N        = 4;
  localparam int         SYNC_SCL      = 0;
  localparam int         SYNC_SDA      = 1;
  localparam int         SYNC_PF       = 2;
  localparam int         SYNC_BAT      = 3;
  localparam logic [3:0] SYNC_RST      = 4'h3;
  // Two-entry write buffer
  localparam logic [1:0] BUF_EMPTY     = 2'h0;
  localparam logic [1:0] BUF_ONE       = 2'h1;
  localparam logic [1:0] BUF_FULL      = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WORD, ST_WORD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_WAIT
  } rssp_state_type;
endpackage

// ### rssp_mem_if.sv
// Purpose: Carrier between port logic and byte memory.
// Assumes: Single clock, one write and one read port.
// Notes:   Read data registered inside the memory.
`timescale 1ns/10ps
interface rssp_mem_if import rssp_pkg::*; ();
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data,
                input rd_addr, output rd_data);
endinterface

// ### rssp_mem.sv
// Purpose: Sixty-four byte location store.
// Assumes: Clock-domain logic as writer and reader.
// Notes:   Array contents undefined after reset, as in real RAM.
`timescale 1ns/10ps
module rssp_mem import rssp_pkg::*; (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  rssp_mem_if.mem   bus
);
  logic [DATA_W-1:0] mem_ff [0:MEM_DEPTH-1];

  // Storage write
  always_ff @(posedge ref_clk_in) begin
    if (bus.wr_en) begin
      mem_ff[bus.wr_addr] <= bus.wr_data;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bus.rd_data <= 8'h00;
    end else begin
      bus.rd_data <= mem_ff[bus.rd_addr];
    end
  end
endmodule

// ### rssp_top.sv
// Purpose: Two-wire slave port of a clock with battery-backed memory.
// Assumes: Bus lines and supply flags asynchronous to ref_clk_in.
// Notes:   Open-drain data: sda_oe_n_out low pulls the line low.
`timescale 1ns/10ps
module rssp_top import rssp_pkg::*; #(
  parameter int unsigned REC_CYCLES = REC_HOLD_CYCLES
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  input  wire logic              power_fail_in,
  input  wire logic              battery_on_in,
  input  wire logic              mem_busy_in,
  output logic                   sda_out,
  output logic                   sda_oe_n_out,
  output logic                   rtc_reset_n_out,
  output logic                   freeze_out,
  output logic [ADDR_W-1:0]      word_pointer_value_out
);
  rssp_mem_if mem_bus ();

  logic [SYNC_N-1:0] sync_raw;
  logic [SYNC_N-1:0] s1_ff;
  logic [SYNC_N-1:0] s2_ff;
  logic              scl_prev_ff;
  logic              sda_prev_ff;
  rssp_state_type    state_ff, nxt_state;
  logic [3:0]        cnt_ff, nxt_cnt;
  logic [7:0]        shift_ff, nxt_shift;
  logic [7:0]        tx_ff, nxt_tx;
  logic              oe_n_ff, nxt_oe_n;
  logic [5:0]        ptr_ff, nxt_ptr;
  logic [19:0]       rec_ff;
  logic              rst_n_ff;
  logic              freeze_ff;
  logic              sda_out_ff;
  logic [13:0]       buf_ff [0:1];
  logic              buf_wr_ff;
  logic              buf_rd_ff;
  logic [1:0]        buf_cnt_ff;

  // Two-stage synchronisers, one per lane
  assign sync_raw = {battery_on_in, power_fail_in, sda_in, scl_in};
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g = g + 1) begin : g_sync
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          s1_ff[g] <= SYNC_RST[g];
          s2_ff[g] <= SYNC_RST[g];
        end else begin
          s1_ff[g] <= sync_raw[g];
          s2_ff[g] <= s1_ff[g];
        end
      end
    end
  endgenerate

  // Previous line levels for edge finding, read from stage two only
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= s2_ff[SYNC_SCL];
      sda_prev_ff <= s2_ff[SYNC_SDA];
    end
  end

  // Line decoding
  wire scl_h     = s2_ff[SYNC_SCL];
  wire sda_h     = s2_ff[SYNC_SDA];
  wire pf_h      = s2_ff[SYNC_PF];
  wire bat_h     = s2_ff[SYNC_BAT];
  wire scl_rise  = scl_h & ~scl_prev_ff;
  wire scl_fall  = ~scl_h & scl_prev_ff;
  wire clk_high  = scl_h & scl_prev_ff;
  wire start_det = clk_high & sda_prev_ff & ~sda_h;
  wire stop_det  = clk_high & ~sda_prev_ff & sda_h;
  wire rec_busy  = (rec_ff != REC_ZERO);
  wire deselect  = pf_h | rec_busy | bat_h;

  // Byte decoding
  wire rx_state  = (state_ff == ST_ADDR) | (state_ff == ST_WORD) |
                   (state_ff == ST_WDATA);
  wire byte_done = rx_state & scl_fall &
                   (cnt_ff == BITS_PER_BYTE);
  wire addr_match = (shift_ff[7:1] == SLAVE_ADDR);
  wire rw_read   = shift_ff[0];
  wire buf_ready = (buf_cnt_ff != BUF_FULL);
  wire buf_push  = byte_done & (state_ff == ST_WDATA) & buf_ready;
  wire drain_ok  = ~mem_busy_in & ~deselect;
  wire buf_pop   = (buf_cnt_ff != BUF_EMPTY) & drain_ok;
  wire ack_clock = scl_rise & ((state_ff == ST_WDATA_ACK) |
                               (state_ff == ST_RACK));
  wire [5:0] ptr_inc = (ptr_ff == LAST_ADDR) ? ADDR_ZERO :
                       (ptr_ff + ADDR_ONE);
  wire [7:0] rd_byte = mem_bus.rd_data;

  // Transfer sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_shift = shift_ff;
    nxt_tx    = tx_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_ptr   = ptr_ff;
    if (deselect) begin
      nxt_state = ST_IDLE;
      nxt_cnt   = BIT_ZERO;
      nxt_oe_n  = 1'b1;
      nxt_ptr   = ADDR_ZERO;
    end else if (start_det) begin
      nxt_state = ST_ADDR;
      nxt_cnt   = BIT_ZERO;
      nxt_oe_n  = 1'b1;
    end else if (stop_det) begin
      nxt_state = ST_IDLE;
      nxt_oe_n  = 1'b1;
    end else begin
      case (state_ff)
        ST_ADDR, ST_WORD, ST_WDATA: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_h};
            nxt_cnt   = cnt_ff + BIT_ONE;
          end else if (byte_done) begin
            nxt_cnt = BIT_ZERO;
            if (state_ff == ST_ADDR) begin
              nxt_state = addr_match ? ST_ADDR_ACK : ST_IDLE;
              nxt_oe_n  = ~addr_match;
            end else if (state_ff == ST_WORD) begin
              nxt_ptr   = shift_ff[5:0];
              nxt_state = ST_WORD_ACK;
              nxt_oe_n  = 1'b0;
            end else if (buf_ready) begin
              nxt_state = ST_WDATA_ACK;
              nxt_oe_n  = 1'b0;
            end else begin
              nxt_state = ST_WAIT; // Buffer full: byte refused
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_read) begin
              nxt_state = ST_RDATA;
              nxt_tx    = rd_byte;
              nxt_oe_n  = rd_byte[7];
            end else begin
              nxt_state = ST_WORD;
              nxt_oe_n  = 1'b1;
            end
          end
        end
        ST_WORD_ACK: begin
          if (scl_fall) begin
            nxt_state = ST_WDATA;
            nxt_oe_n  = 1'b1;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_rise) begin
            nxt_ptr = ptr_inc;
          end else if (scl_fall) begin
            nxt_state = ST_WDATA;
            nxt_oe_n  = 1'b1;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + BIT_ONE;
          end else if (scl_fall) begin
            if (cnt_ff == BITS_PER_BYTE) begin
              nxt_state = ST_RACK;
              nxt_cnt   = BIT_ZERO;
              nxt_oe_n  = 1'b1;
            end else begin
              nxt_tx   = {tx_ff[6:0], 1'b1};
              nxt_oe_n = tx_ff[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nxt_ptr      = ptr_inc;
            nxt_shift[0] = sda_h;
          end else if (scl_fall) begin
            if (!shift_ff[0]) begin
              nxt_state = ST_RDATA;
              nxt_tx    = rd_byte;
              nxt_oe_n  = rd_byte[7];
            end else begin
              nxt_state = ST_WAIT;
            end
          end
        end
        ST_IDLE, ST_WAIT: begin
          nxt_oe_n = 1'b1;
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_oe_n  = 1'b1;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= BIT_ZERO;
      shift_ff <= 8'h00;
      tx_ff    <= 8'hFF;
      oe_n_ff  <= 1'b1;
      ptr_ff   <= ADDR_ZERO;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      shift_ff <= nxt_shift;
      tx_ff    <= nxt_tx;
      oe_n_ff  <= nxt_oe_n;
      ptr_ff   <= nxt_ptr;
    end
  end

  // Recovery hold: reloaded while supply is low, counts after it returns
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rec_ff <= REC_ZERO;
    end else if (pf_h) begin
      rec_ff <= REC_CYCLES[REC_CNT_W-1:0];
    end else if (rec_busy) begin
      rec_ff <= rec_ff - REC_ONE;
    end
  end

  // Status outputs; freeze only while a transfer sits on a clock byte
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rst_n_ff   <= 1'b0;
      freeze_ff  <= 1'b0;
      sda_out_ff <= 1'b0;
    end else begin
      rst_n_ff   <= ~(pf_h | rec_busy);
      freeze_ff  <= (state_ff != ST_IDLE) & ~deselect &
                    (ptr_ff <= CLOCK_LAST);
      sda_out_ff <= 1'b0;
    end
  end

  // Two-entry write buffer; a full buffer makes the port refuse the byte
  always_ff @(posedge ref_clk_in) begin
    if (buf_push) begin
      buf_ff[buf_wr_ff] <= {ptr_ff, shift_ff};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      buf_wr_ff  <= 1'b0;
      buf_rd_ff  <= 1'b0;
      buf_cnt_ff <= BUF_EMPTY;
    end else begin
      buf_wr_ff  <= buf_wr_ff ^ buf_push;
      buf_rd_ff  <= buf_rd_ff ^ buf_pop;
      buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Memory hookup: reads follow the pointer continuously
  assign mem_bus.wr_en   = buf_pop;
  assign mem_bus.wr_addr = buf_ff[buf_rd_ff][13:8];
  assign mem_bus.wr_data = buf_ff[buf_rd_ff][7:0];
  assign mem_bus.rd_addr = ptr_ff;

  rssp_mem u_mem (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .bus        (mem_bus.mem)
  );

  assign sda_out                = sda_out_ff;
  assign sda_oe_n_out           = oe_n_ff;
  assign rtc_reset_n_out        = rst_n_ff;
  assign freeze_out             = freeze_ff;
  assign word_pointer_value_out = ptr_ff;

  // Checks
  property p_addr_nomatch;
    @(posedge ref_clk_in) disable iff (rst_in)
    (byte_done && state_ff == ST_ADDR && !addr_match && !deselect &&
     !start_det && !stop_det) |=> (state_ff == ST_IDLE) && oe_n_ff;
  endproperty
  a_addr_nomatch: assert property (p_addr_nomatch)
    else $error("Foreign address answered");

  property p_addr_ack;
    @(posedge ref_clk_in) disable iff (rst_in)
    (byte_done && state_ff == ST_ADDR && addr_match && !deselect &&
     !start_det && !stop_det) |=> !oe_n_ff && state_ff == ST_ADDR_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("Own address not acknowledged");

  property p_deselect_clear;
    @(posedge ref_clk_in) disable iff (rst_in)
    deselect |=> (ptr_ff == ADDR_ZERO) && (state_ff == ST_IDLE);
  endproperty
  a_deselect_clear: assert property (p_deselect_clear)
    else $error("Deselect left pointer or transfer");

  property p_recovery_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    $fell(pf_h) |=> (!rst_n_ff && !buf_pop) [*8];
  endproperty
  a_recovery_hold: assert property (p_recovery_hold)
    else $error("Access reopened before recovery");

  property p_reset_out;
    @(posedge ref_clk_in) disable iff (rst_in)
    pf_h |=> !rst_n_ff;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("Reset output not asserted on power fail");

  property p_battery_release;
    @(posedge ref_clk_in) disable iff (rst_in)
    bat_h |=> ##1 oe_n_ff;
  endproperty
  a_battery_release: assert property (p_battery_release)
    else $error("Data line driven on battery");

  property p_ack_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ST_WDATA_ACK && clk_high && !deselect) |-> !oe_n_ff;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("Acknowledge released during clock high");

  property p_master_ack_free;
    @(posedge ref_clk_in) disable iff (rst_in)
    (state_ff == ST_RACK || state_ff == ST_WAIT) |-> oe_n_ff;
  endproperty
  a_master_ack_free: assert property (p_master_ack_free)
    else $error("Slave holds line in master acknowledge");

  property p_ptr_advance;
    @(posedge ref_clk_in) disable iff (rst_in)
    (ack_clock && !deselect && !start_det && !stop_det) |=>
      ptr_ff == (($past(ptr_ff) == LAST_ADDR) ? ADDR_ZERO :
                 $past(ptr_ff) + ADDR_ONE);
  endproperty
  a_ptr_advance: assert property (p_ptr_advance)
    else $error("Pointer did not advance or wrap");

  property p_stop_unfreeze;
    @(posedge ref_clk_in) disable iff (rst_in)
    stop_det |-> ##2 !freeze_ff;
  endproperty
  a_stop_unfreeze: assert property (p_stop_unfreeze)
    else $error("Freeze held after STOP");

  property p_start_seen;
    @(posedge ref_clk_in) disable iff (rst_in)
    (start_det && !deselect) |=> state_ff == ST_ADDR && cnt_ff == BIT_ZERO;
  endproperty
  a_start_seen: assert property (p_start_seen)
    else $error("START not taken");
endmodule

// ### rssp_master_model.sv
// Purpose: Two-wire bus master standing opposite the slave port.
// Assumes: Pull-up on data; 80 ns bus clock, still between frames.
// Notes:   Bench calls the tasks; data bits change only mid-low, start and stop move data with clock high.
`timescale 1ns/10ps
module rssp_master_model (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_n_out
);
  // Quarter of an 80 ns bus clock period
  localparam time QTR = 20ns;

  // Bus idles with both lines high
  initial begin
    scl_out      = 1'b1;
    sda_oe_n_out = 1'b1;
  end

  // One pulse per bit; data moves only while clock low
  task automatic clk_bit(input logic b, output logic s);
    #QTR sda_oe_n_out = b;
    #QTR scl_out = 1'b1;
    #QTR s = sda_in;
    #QTR scl_out = 1'b0;
  endtask

  // Data falls while clock high; doubles as repeated start
  task automatic start_cond();
    #QTR sda_oe_n_out = 1'b1;
    #QTR scl_out = 1'b1;
    #QTR sda_oe_n_out = 1'b0;
    #QTR scl_out = 1'b0;
  endtask

  // Data rises while clock high, then the bus stands idle
  task automatic stop_cond();
    #QTR sda_oe_n_out = 1'b0;
    #QTR scl_out = 1'b1;
    #QTR sda_oe_n_out = 1'b1;
    #QTR;
  endtask

  // Byte out MSB first, ninth pulse samples the answer
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  // Low ack asks for more, high ends it
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~more, s);
  endtask
endmodule

// ### tb.sv
// Purpose: Self-checking bench of the two-wire slave port.
// Assumes: Short recovery hold; master model drives the bus.
// Notes:   Memory is not reset, so every read follows a write.
`timescale 1ns/10ps
module tb import rssp_pkg::*; ;
  localparam int REC = 16;
  logic       clk;
  logic       rst;
  logic       pf;
  logic       bat;
  logic       busy;
  logic       scl;
  logic       m_oe_n;
  logic       sda_o;
  logic       oe_n;
  logic       rst_n;
  logic       frz;
  logic [5:0] ptr;
  wire        sda_w;
  int         miscompares;
  int         checks_done;

  // Open-drain data line with pull-up
  assign sda_w = (oe_n | sda_o) & m_oe_n;

  rssp_top #(.REC_CYCLES(REC)) i_dut (
    .ref_clk_in             (clk),
    .rst_in                 (rst),
    .scl_in                 (scl),
    .sda_in                 (sda_w),
    .power_fail_in          (pf),
    .battery_on_in          (bat),
    .mem_busy_in            (busy),
    .sda_out                (sda_o),
    .sda_oe_n_out           (oe_n),
    .rtc_reset_n_out        (rst_n),
    .freeze_out             (frz),
    .word_pointer_value_out (ptr)
  );

  rssp_master_model i_mst (
    .sda_in       (sda_w),
    .scl_out      (scl),
    .sda_oe_n_out (m_oe_n)
  );

  // 125 MHz reference clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] e, input logic [7:0] a);
    checks_done++;
    if (a !== e) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  // Inputs move one step after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [7:0] d, input logic exp);
    logic ack;
    i_mst.wr_byte(d, ack);
    cmp({7'h00, exp}, {7'h00, ack});
  endtask

  task automatic set_ptr(input logic [7:0] w);
    i_mst.start_cond();
    send(8'hD0, 1'b1);
    send(w, 1'b1);
  endtask

  task automatic get(input logic more, input logic [7:0] e);
    logic [7:0] d;
    i_mst.rd_byte(more, d);
    cmp(e, d);
  endtask

  // Three bytes written across the top of memory
  task automatic t_write_wrap();
    set_ptr(8'h3F);
    send(8'hA1, 1'b1);
    send(8'hB2, 1'b1);
    send(8'hC3, 1'b1);
    i_mst.stop_cond();
    cyc(4);
    cmp(8'h02, {2'h0, ptr});
    cmp(8'h00, {7'h00, sda_o});
  endtask

  // Read without a word address starts at the held pointer
  task automatic t_current_read();
    set_ptr(8'h00);
    i_mst.stop_cond();
    i_mst.start_cond();
    send(8'hD1, 1'b1);
    get(1'b1, 8'hB2);
    get(1'b0, 8'hC3);
    cmp(8'h01, {7'h00, oe_n});
    i_mst.stop_cond();
    cyc(4);
    cmp(8'h02, {2'h0, ptr});
  endtask

  // Combined read crossing into the clock bytes
  task automatic t_combined_read();
    set_ptr(8'h3F);
    cmp(8'h00, {7'h00, frz});
    i_mst.start_cond();
    send(8'hD1, 1'b1);
    get(1'b1, 8'hA1);
    get(1'b1, 8'hB2);
    cmp(8'h01, {7'h00, frz});
    get(1'b0, 8'hC3);
    i_mst.stop_cond();
    cyc(6);
    cmp(8'h00, {7'h00, frz});
  endtask

  // Foreign address is ignored until the next start
  task automatic t_bad_addr();
    i_mst.start_cond();
    send(8'hD2, 1'b0);
    send(8'hD0, 1'b0);
    i_mst.stop_cond();
  endtask

  // Stalled memory: third byte refused, first two kept
  task automatic t_buffer();
    cyc(1);
    busy = 1'b1;
    set_ptr(8'h20);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b0);
    i_mst.stop_cond();
    cyc(2);
    busy = 1'b0;
    cyc(8);
    set_ptr(8'h20);
    i_mst.start_cond();
    send(8'hD1, 1'b1);
    get(1'b1, 8'h11);
    get(1'b0, 8'h22);
    i_mst.stop_cond();
  endtask

  // Supply loss mid-transfer, battery, then recovery hold
  task automatic t_deselect();
    int cnt;
    cnt = 0;
    i_mst.start_cond();
    send(8'hD0, 1'b1);
    cyc(1);
    pf = 1'b1;
    cyc(8);
    cmp(8'h01, {7'h00, oe_n});
    cmp(8'h00, {2'h0, ptr});
    cmp(8'h00, {7'h00, rst_n});
    send(8'h00, 1'b0);
    i_mst.stop_cond();
    cyc(1);
    bat = 1'b1;
    i_mst.start_cond();
    send(8'hD0, 1'b0);
    i_mst.stop_cond();
    cmp(8'h01, {7'h00, oe_n});
    cyc(1);
    bat = 1'b0;
    pf = 1'b0;
    while (rst_n !== 1'b1 && cnt < 200) begin
      cyc(1);
      cnt++;
    end
    if (cnt >= 200) begin
      miscompares++;
      close_out();
    end
    cmp(8'h01, {7'h00, (cnt >= REC && cnt <= REC + 8)});
    cyc(4);
    i_mst.start_cond();
    send(8'hD0, 1'b1);
    i_mst.stop_cond();
  endtask

  // Reset for 8 cycles, then scenarios in order
  initial begin
    miscompares = 0;
    checks_done = 0;
    rst = 1'b1;
    pf = 1'b0;
    bat = 1'b0;
    busy = 1'b0;
    cyc(8);
    rst = 1'b0;
    cyc(6);
    cmp(8'h01, {7'h00, rst_n});
    t_write_wrap();
    t_current_read();
    t_combined_read();
    t_bad_addr();
    t_buffer();
    t_deselect();
    cyc(4);
    close_out();
  end
endmodule
